// ### hdl/bfm_top.sv
// ball function resolution and global interrupt status aggregation
`timescale 1ns/1ps
`default_nettype none
`include "bfm_consts.svh"

module bfm_top
  import bfm_pkg::*;
#(
  parameter int NUM_BALLS = 20
) (
  // clock and synchronous reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port from the serial slave
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // keypad module settings and scan drive
  input wire logic [3:0] MATRIX_IN_CNT,
  input wire logic [3:0] MATRIX_OUT_CNT,
  input wire logic [NUM_BALLS-1:0] DEDICATED_KEY,
  input wire logic [11:0] SCAN_DRIVE,
  // io module settings
  input wire bfm_io_cfg_s IO_CFG,
  // pulse outputs from the timers
  input wire logic [2:0] PULSE_IN,
  // interrupt sources
  input wire logic SUPPLY_FAIL,
  input wire logic SUPPLY_ACK,
  input wire logic KEYPAD_IRQ,
  input wire logic IO_IRQ,
  input wire bfm_timer_evt_s TIMER_EVT,
  // balls
  input wire logic [NUM_BALLS-1:0] BALL_IN,
  output logic [NUM_BALLS-1:0] BALL_OUT,
  output logic [NUM_BALLS-1:0] BALL_OE,
  output logic [NUM_BALLS-1:0] BALL_PULL_UP,
  output logic [NUM_BALLS-1:0] BALL_PULL_DN,
  output logic [NUM_BALLS-1:0] BALL_SYNC,
  // status view
  output logic [7:0] STATUS,
  output logic HOST_IRQ_N
);

  // ==========================================================
  // internal state
  logic [7:0] status_r;                // global interrupt status
  logic [7:0] pinmap_r;                // pin mapping, write only
  logic [NUM_BALLS-1:0] sync1_r;       // first synchroniser stage
  logic [NUM_BALLS-1:0] sync2_r;       // second synchroniser stage
  logic [2:0] fsel;                    // ball function select field
  logic irq_sel;                       // interrupt on last column
  logic any_irq;                       // any status bit standing
  logic [2:0] timer_set;               // timer bit set requests
  bfm_ball_fn_e map_fn [NUM_BALLS];    // function from pin mapping
  logic [1:0] map_pulse [NUM_BALLS];   // pulse index for mapped balls
  logic [NUM_BALLS-1:0] scan_vec;      // scan drive aligned to balls

  assign fsel = pinmap_r[`BFM_PM_FSEL_MSB:0];
  assign irq_sel = pinmap_r[`BFM_PM_IRQSEL_BIT];
  assign any_irq = |status_r;
  assign timer_set = TIMER_EVT.countdown | TIMER_EVT.cycle;
  assign scan_vec = {SCAN_DRIVE, 8'h00};

  // ==========================================================
  // register writes: only the pin mapping lives here
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pinmap_r <= `BFM_PINMAP_RESET;
    end else if (REG_WR_EN && REG_ADDR == `BFM_PINMAP_ADDR) begin
      // reserved bits 7:5 and 3 are forced to zero
      pinmap_r <= {3'h0, REG_WDATA[`BFM_PM_IRQSEL_BIT], 1'b0,
                   REG_WDATA[`BFM_PM_FSEL_MSB:0]};
    end
  end

  // ==========================================================
  // register reads: one cycle latency, unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD_EN;
      if (REG_RD_EN && REG_ADDR == `BFM_STATUS_ADDR) begin
        REG_RDATA <= status_r;
      end else begin
        // pin mapping is write only, so it reads as zero too
        REG_RDATA <= 8'h00;
      end
    end
  end

  // ==========================================================
  // supply-fail flag: power-on counts as a failure
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_r[`BFM_ST_SUPPLY_BIT] <= 1'b1;
    end else if (SUPPLY_FAIL) begin
      // set beats a clear in the same cycle
      status_r[`BFM_ST_SUPPLY_BIT] <= 1'b1;
    end else if (SUPPLY_ACK) begin
      status_r[`BFM_ST_SUPPLY_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // keypad and io bits mirror their modules; cause lives there
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_r[`BFM_ST_KEYPAD_BIT] <= 1'b0;
      status_r[`BFM_ST_IO_BIT] <= 1'b0;
    end else begin
      status_r[`BFM_ST_KEYPAD_BIT] <= KEYPAD_IRQ;
      status_r[`BFM_ST_IO_BIT] <= IO_IRQ;
    end
  end

  // reserved bits read as zero
  always_ff @(posedge CLK) begin
    status_r[5:4] <= 2'h0;
  end

  // ==========================================================
  // timer expiry bits: sticky, one per timer
  generate
    for (genvar t = 0; t < 3; t++) begin : g_timer
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          status_r[`BFM_ST_TIMER_LSB + t] <= 1'b0;
        end else if (timer_set[t]) begin
          // an event in the acknowledge cycle is kept
          status_r[`BFM_ST_TIMER_LSB + t] <= 1'b1;
        end else if (TIMER_EVT.ack[t]) begin
          status_r[`BFM_ST_TIMER_LSB + t] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // status view and active-low interrupt, only when configured
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      STATUS <= `BFM_STATUS_RESET;
      HOST_IRQ_N <= 1'b1;
    end else begin
      STATUS <= status_r;
      HOST_IRQ_N <= ~(any_irq & irq_sel);
    end
  end

  // ==========================================================
  // pin mapping of the four extra column balls
  always_comb begin
    for (int i = 0; i < NUM_BALLS; i++) begin
      map_fn[i] = FN_IO;
      map_pulse[i] = 2'h0;
    end
    case (fsel)
      `BFM_FSEL_KEYPAD: begin
        // extra columns stay keypad or io 16..19
        map_fn[`BFM_COL11_BALL] = FN_IO;
      end
      `BFM_FSEL_PULSE: begin
        map_fn[`BFM_COL9_BALL] = FN_PULSE;
        map_pulse[`BFM_COL9_BALL] = 2'h1;
        map_fn[`BFM_COL10_BALL] = FN_PULSE;
        map_pulse[`BFM_COL10_BALL] = 2'h0;
        if (irq_sel) begin
          // pulse 2 moves to column 8 when the last column is the irq
          map_fn[`BFM_COL8_BALL] = FN_PULSE;
          map_pulse[`BFM_COL8_BALL] = 2'h2;
        end else begin
          map_fn[`BFM_COL11_BALL] = FN_PULSE;
          map_pulse[`BFM_COL11_BALL] = 2'h2;
        end
      end
      `BFM_FSEL_LAST: begin
        // columns 8..10 unused; only the last column carries pulse 2
        map_fn[`BFM_COL8_BALL] = FN_NONE;
        map_fn[`BFM_COL9_BALL] = FN_NONE;
        map_fn[`BFM_COL10_BALL] = FN_NONE;
        map_fn[`BFM_COL11_BALL] = FN_PULSE;
        map_pulse[`BFM_COL11_BALL] = 2'h2;
      end
      default: begin
        // invalid selects leave the extra balls quiet and undriven
        map_fn[`BFM_COL8_BALL] = FN_NONE;
        map_fn[`BFM_COL9_BALL] = FN_NONE;
        map_fn[`BFM_COL10_BALL] = FN_NONE;
        map_fn[`BFM_COL11_BALL] = FN_NONE;
      end
    endcase
    if (irq_sel) begin
      // interrupt select wins on the last column for every select
      map_fn[`BFM_COL11_BALL] = FN_IRQ;
    end
  end

  // ==========================================================
  // ball input synchroniser; only the second stage is read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
      BALL_SYNC <= '0;
    end else begin
      sync1_r <= BALL_IN;
      sync2_r <= sync1_r;
      BALL_SYNC <= sync2_r;
    end
  end

  // ==========================================================
  // per ball function resolution and pad control
  generate
    for (genvar b = 0; b < NUM_BALLS; b++) begin : g_ball
      bfm_ball_fn_e fn;   // resolved function
      logic in_matrix;    // ball inside selected matrix size
      logic drv_val;      // io level
      logic [1:0] pull;   // host pull setting

      assign drv_val = IO_CFG.value[b];
      assign pull = IO_CFG.pull[2*b+1:2*b];

      // resolution in fixed priority order
      always_comb begin
        if (b < `BFM_NUM_IN_BALLS) begin
          in_matrix = (4'(b) < MATRIX_IN_CNT);
        end else begin
          in_matrix = (4'(b - `BFM_NUM_IN_BALLS) < MATRIX_OUT_CNT);
        end
        if (in_matrix) begin
          // matrix size first; also covers a dedicated key inside it
          fn = (b < `BFM_NUM_IN_BALLS) ? FN_MATRIX_IN : FN_MATRIX_OUT;
        end else if (DEDICATED_KEY[b]) begin
          fn = FN_DEDICATED;
        end else if (map_fn[b] != FN_IO) begin
          // mapping beats io direction, so an input can still pulse
          fn = map_fn[b];
        end else begin
          fn = FN_IO;
        end
      end

      // pad drive, direction and pulls from the resolved function
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          BALL_OUT[b] <= 1'b0;
          BALL_OE[b] <= 1'b0;
          BALL_PULL_UP[b] <= 1'b0;
          BALL_PULL_DN[b] <= 1'b0;
        end else begin
          case (fn)
            FN_MATRIX_IN: begin
              // host settings are overridden for keypad balls
              BALL_OUT[b] <= 1'b0;
              BALL_OE[b] <= 1'b0;
              BALL_PULL_UP[b] <= 1'b1;
              BALL_PULL_DN[b] <= 1'b0;
            end
            FN_MATRIX_OUT: begin
              // open-drain scan drive, pulled by the inputs only
              BALL_OUT[b] <= 1'b0;
              BALL_OE[b] <= scan_vec[b];
              BALL_PULL_UP[b] <= 1'b0;
              BALL_PULL_DN[b] <= 1'b0;
            end
            FN_DEDICATED: begin
              BALL_OUT[b] <= 1'b0;
              BALL_OE[b] <= 1'b0;
              BALL_PULL_UP[b] <= 1'b1;
              BALL_PULL_DN[b] <= 1'b0;
            end
            FN_PULSE: begin
              // full push-pull so the led edge stays sharp
              BALL_OUT[b] <= PULSE_IN[map_pulse[b]];
              BALL_OE[b] <= 1'b1;
              BALL_PULL_UP[b] <= 1'b0;
              BALL_PULL_DN[b] <= 1'b0;
            end
            FN_IRQ: begin
              // open drain so several devices can share the line
              BALL_OUT[b] <= 1'b0;
              BALL_OE[b] <= any_irq;
              BALL_PULL_UP[b] <= 1'b0;
              BALL_PULL_DN[b] <= 1'b0;
            end
            FN_IO: begin
              BALL_PULL_UP[b] <= pull[1];
              BALL_PULL_DN[b] <= (pull == 2'h1);
              if (!IO_CFG.mode_en[b]) begin
                // full push-pull
                BALL_OUT[b] <= drv_val;
                BALL_OE[b] <= IO_CFG.dir[b];
              end else if (!IO_CFG.mode_sel[b]) begin
                // open drain: drive low only
                BALL_OUT[b] <= 1'b0;
                BALL_OE[b] <= IO_CFG.dir[b] & ~drv_val;
              end else begin
                // open source: drive high only
                BALL_OUT[b] <= 1'b1;
                BALL_OE[b] <= IO_CFG.dir[b] & drv_val;
              end
            end
            default: begin
              // unused ball: floating input, no pulls
              BALL_OUT[b] <= 1'b0;
              BALL_OE[b] <= 1'b0;
              BALL_PULL_UP[b] <= 1'b0;
              BALL_PULL_DN[b] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

endmodule // bfm_top

`default_nettype wire

// ### hdl/bfm_consts.svh
// constants for the ball function mux and global interrupt status block
`ifndef BFM_CONSTS_SVH
`define BFM_CONSTS_SVH

// ============================================================
// register offsets
`define BFM_STATUS_ADDR 8'h91
`define BFM_PINMAP_ADDR 8'hA7

// ============================================================
// global interrupt status layout and reset value
`define BFM_ST_SUPPLY_BIT 7
`define BFM_ST_KEYPAD_BIT 6
`define BFM_ST_TIMER2_BIT 3
`define BFM_ST_TIMER1_BIT 2
`define BFM_ST_TIMER0_BIT 1
`define BFM_ST_IO_BIT 0
`define BFM_ST_TIMER_LSB 1
`define BFM_STATUS_RESET 8'h80

// ============================================================
// pin mapping layout, codes and reset value
`define BFM_PM_IRQSEL_BIT 4
`define BFM_PM_FSEL_MSB 2
`define BFM_PINMAP_RESET 8'h00
`define BFM_FSEL_KEYPAD 3'h0
`define BFM_FSEL_PULSE 3'h1
`define BFM_FSEL_LAST 3'h2

// ============================================================
// ball numbering: inputs 0..7, outputs 8..19
`define BFM_NUM_IN_BALLS 8
`define BFM_FIRST_EXTRA 16
`define BFM_COL8_BALL 16
`define BFM_COL9_BALL 17
`define BFM_COL10_BALL 18
`define BFM_COL11_BALL 19

`endif

// ### hdl/bfm_pkg.sv
// types shared by the ball function mux and status block
package bfm_pkg;

  // ==========================================================
  // resolved function of one ball
  typedef enum logic [2:0] {
    FN_IO,
    FN_MATRIX_IN,
    FN_MATRIX_OUT,
    FN_DEDICATED,
    FN_PULSE,
    FN_IRQ,
    FN_NONE
  } bfm_ball_fn_e;

  // ==========================================================
  // host io settings for all twenty balls, from the io module
  typedef struct packed {
    logic [19:0] dir;       // 1 = output
    logic [19:0] mode_en;   // 1 = single-ended driver
    logic [19:0] mode_sel;  // 0 = open drain, 1 = open source
    logic [19:0] value;     // output level from the io module
    logic [39:0] pull;      // 2 bits per ball: 00 none, 01 down, 1x up
  } bfm_io_cfg_s;

  // timer events and their acknowledge from the timer block
  typedef struct packed {
    logic [2:0] countdown;
    logic [2:0] cycle;
    logic [2:0] ack;
  } bfm_timer_evt_s;

endpackage : bfm_pkg

// ### test/bfm_top_sva.sv
// port assertions for the ball function mux and status block
`timescale 1ns/1ps
`default_nettype none
`include "bfm_consts.svh"
module bfm_top_sva
  import bfm_pkg::*;
#(
  parameter int NUM_BALLS = 20
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic REG_RD_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // sources
  input wire logic [3:0] MATRIX_IN_CNT,
  input wire logic SUPPLY_FAIL,
  input wire logic SUPPLY_ACK,
  input wire logic KEYPAD_IRQ,
  input wire bfm_timer_evt_s TIMER_EVT,
  // outputs
  input wire logic [NUM_BALLS-1:0] BALL_OE,
  input wire logic [NUM_BALLS-1:0] BALL_PULL_UP,
  input wire logic [NUM_BALLS-1:0] BALL_PULL_DN,
  input wire logic [7:0] STATUS,
  input wire logic HOST_IRQ_N
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ======
  // read requests, status versus anything else
  sequence s_rd_status;
    REG_RD_EN && REG_ADDR == `BFM_STATUS_ADDR;
  endsequence
  sequence s_rd_other;
    REG_RD_EN && REG_ADDR != `BFM_STATUS_ADDR;
  endsequence
  // read data matches the status copy of the same edge
  a_status_read: assert property (s_rd_status |=> REG_RVALID && REG_RDATA == STATUS)
    else $error("status read data wrong");
  a_other_read_zero: assert property (s_rd_other |=> REG_RVALID && REG_RDATA == 8'h00)
    else $error("non-status read not zero");
  a_idle_read: assert property (!REG_RD_EN |=> !REG_RVALID && REG_RDATA == 8'h00)
    else $error("read answer without request");
  // interrupt line stays high while nothing is pending
  a_irq_idle: assert property (STATUS == 8'h00 |-> HOST_IRQ_N)
    else $error("interrupt line low with empty status");
  a_reserved_zero: assert property (STATUS[5:4] == 2'h0)
    else $error("reserved status bits set");
  // sources reach the status copy two edges later
  a_keypad_flag: assert property ($rose(KEYPAD_IRQ) |-> ##2 STATUS[6])
    else $error("keypad flag not raised");
  a_timer0_flag: assert property (
    TIMER_EVT.countdown[0] || TIMER_EVT.cycle[0] |-> ##2 STATUS[1])
    else $error("timer 0 flag not raised");
  a_supply_clear: assert property (SUPPLY_ACK && !SUPPLY_FAIL |-> ##2 !STATUS[7])
    else $error("supply flag not cleared");
  // a matrix input ball is pulled up and never driven
  a_matrix_in_pull: assert property (MATRIX_IN_CNT != 4'h0 |=>
    BALL_PULL_UP[0] && !BALL_PULL_DN[0] && !BALL_OE[0])
    else $error("matrix input ball misconfigured");
endmodule // bfm_top_sva

bind bfm_top bfm_top_sva #(.NUM_BALLS(NUM_BALLS)) i_bfm_top_sva (
  .CLK(CLK), .RST_N(RST_N), .REG_RD_EN(REG_RD_EN), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .MATRIX_IN_CNT(MATRIX_IN_CNT),
  .SUPPLY_FAIL(SUPPLY_FAIL), .SUPPLY_ACK(SUPPLY_ACK), .KEYPAD_IRQ(KEYPAD_IRQ),
  .TIMER_EVT(TIMER_EVT), .BALL_OE(BALL_OE), .BALL_PULL_UP(BALL_PULL_UP),
  .BALL_PULL_DN(BALL_PULL_DN), .STATUS(STATUS), .HOST_IRQ_N(HOST_IRQ_N)
);
`default_nettype wire

// ### test/bfm_pad_model.sv
// pad model: resolves each ball level from driver and pull resistors
`timescale 1ns/1ps
`default_nettype none
module bfm_pad_model #(
  parameter int NUM_BALLS = 20
) (
  // clock for the floating pattern
  input wire logic CLK,
  // pad controls
  input wire logic [NUM_BALLS-1:0] BALL_OUT,
  input wire logic [NUM_BALLS-1:0] BALL_OE,
  input wire logic [NUM_BALLS-1:0] BALL_PULL_UP,
  input wire logic [NUM_BALLS-1:0] BALL_PULL_DN,
  // resolved levels
  output logic [NUM_BALLS-1:0] BALL_IN
);
  // an undriven unpulled ball toggles so no stale level can pass
  logic [NUM_BALLS-1:0] float_r = '0;
  // ======
  // floating pattern
  always_ff @(posedge CLK) begin
    float_r <= ~float_r;
  end
  // driver first, then pull resistor, else floating
  always_comb begin
    for (int i = 0; i < NUM_BALLS; i++) begin
      BALL_IN[i] = BALL_OE[i] ? BALL_OUT[i] : BALL_PULL_UP[i] ? 1'h1 :
        BALL_PULL_DN[i] ? 1'h0 : float_r[i];
    end
  end
endmodule // bfm_pad_model
`default_nettype wire

// ### test/tb_top.sv
// testbench for the ball function mux and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bfm_pkg::*;
  logic clk = 1'h0;
  logic rst_n, wr_en, rd_en, rvalid, irq_n, s_fail, s_ack, kbd, gio;
  logic [7:0] addr, wdata, rdata, status;
  logic [3:0] in_cnt, out_cnt;
  logic [11:0] scan;
  logic [2:0] pulse;
  logic [19:0] ded, b_in, b_out, b_oe, p_up, p_dn, b_sync;
  bfm_io_cfg_s io;
  bfm_timer_evt_s tev;
  int n_fail, n_tests, cyc;
  // ======
  // clock, design and pad model
  always #25 clk = ~clk;
  bfm_top i_bfm_top (.CLK(clk), .RST_N(rst_n), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .MATRIX_IN_CNT(in_cnt), .MATRIX_OUT_CNT(out_cnt), .DEDICATED_KEY(ded),
    .SCAN_DRIVE(scan), .IO_CFG(io), .PULSE_IN(pulse), .SUPPLY_FAIL(s_fail),
    .SUPPLY_ACK(s_ack), .KEYPAD_IRQ(kbd), .IO_IRQ(gio), .TIMER_EVT(tev), .BALL_IN(b_in),
    .BALL_OUT(b_out), .BALL_OE(b_oe), .BALL_PULL_UP(p_up), .BALL_PULL_DN(p_dn),
    .BALL_SYNC(b_sync), .STATUS(status), .HOST_IRQ_N(irq_n));
  bfm_pad_model i_bfm_pad_model (.CLK(clk), .BALL_OUT(b_out), .BALL_OE(b_oe),
    .BALL_PULL_UP(p_up), .BALL_PULL_DN(p_dn), .BALL_IN(b_in));
  // ======
  // helpers: compare, wait, register cycles
  // wide enough for three eight-ball groups in one compare
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle strobes, then a gap so strobes never toggle twice at once
  task wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'h1;
    addr = a;
    wdata = d;
    step(1);
    wr_en = 1'h0;
    step(3);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    rd_en = 1'h1;
    addr = a;
    step(1);
    rd_en = 1'h0;
    chk({rvalid, rdata}, {1'h1, exp});
    step(1);
    chk({rvalid, rdata}, 20'h00000);
  endtask
  task results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ======
  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  // ======
  // main sequence
  initial begin
    {rst_n, wr_en, rd_en, s_fail, s_ack, kbd, gio, addr, wdata} = '0;
    {in_cnt, out_cnt, scan, pulse, ded, io, tev} = '0;
    step(2);
    rst_n = 1'h1;
    chk({status, irq_n}, {8'h80, 1'h1});
    rd(8'h91, 8'h80);
    rd(8'hA7, 8'h00);
    wr(8'h91, 8'hFF);
    rd(8'h91, 8'h80);
    // a supply failure in the acknowledge cycle keeps the flag
    {s_fail, s_ack} = 2'h3;
    step(1);
    {s_fail, s_ack} = 2'h0;
    step(3);
    rd(8'h91, 8'h80);
    s_ack = 1'h1;
    step(1);
    s_ack = 1'h0;
    step(3);
    rd(8'h91, 8'h00);
    // every timer with both of its events, then acknowledge
    for (int t = 0; t < 3; t++) begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0) tev.countdown[t] = 1'h1;
        // cycle event lands together with an acknowledge: set must win
        else {tev.cycle[t], tev.ack[t]} = 2'h3;
        step(1);
        tev = '0;
        step(3);
        rd(8'h91, 8'(8'h02 << t));
        tev.ack[t] = 1'h1;
        step(1);
        tev.ack = '0;
        step(3);
        rd(8'h91, 8'h00);
      end
    end
    kbd = 1'h1;
    step(3);
    rd(8'h91, 8'h40);
    gio = 1'h1;
    step(3);
    rd(8'h91, 8'h41);
    // interrupt output on the last column
    wr(8'hA7, 8'h10);
    chk({irq_n, b_oe[19], b_out[19]}, 3'h2);
    {kbd, gio} = '0;
    step(3);
    chk({irq_n, b_oe[19]}, 2'h2);
    // pulse 2 moves between column 8 and the last column
    pulse = 3'h4;
    wr(8'hA7, 8'h11);
    chk({b_out[16], b_out[19]}, 2'h2);
    wr(8'hA7, 8'h01);
    chk({b_oe[16], b_out[19]}, 2'h1);
    // pulses 1 and 0 beat an input direction
    for (int p = 1; p < 3; p++) begin
      pulse = 3'(p);
      step(3);
      chk({b_oe[18:17], b_out[18:17]}, {2'h3, pulse[0], pulse[1]});
    end
    // function select 2: columns 8..10 idle despite host pulls
    pulse = 3'h4;
    io.pull = '1;
    wr(8'hA7, 8'h02);
    chk({p_up[18:16], b_oe[19:16], b_out[19]}, 8'h11);
    io = '0;
    // function select 0: extra column as host io, then open drain
    wr(8'hA7, 8'h00);
    io.dir[17] = 1'h1;
    io.value[17] = 1'h1;
    io.pull[35:34] = 2'h1;
    step(3);
    chk({b_oe[17], b_out[17], p_dn[17]}, 3'h7);
    io.mode_en[17] = 1'h1;
    step(3);
    chk({b_oe[17], b_out[17]}, 2'h0);
    // open source drives the high level only
    io.mode_sel[17] = 1'h1;
    step(3);
    chk({b_oe[17], b_out[17]}, 2'h3);
    // keypad overrides host settings
    io = '0;
    io.dir = '1;
    io.value = '1;
    io.pull = {20{2'h1}};
    {in_cnt, out_cnt, ded, scan} = {4'h8, 4'h8, 20'h00004, 12'h2A5};
    step(3);
    chk({p_up[7:0], p_dn[7:0], b_oe[7:0]}, 24'hFF0000);
    chk({p_up[15:8], p_dn[15:8]}, 24'h000000);
    chk({b_oe[15:8], b_out[15:8]}, 24'h00A500);
    // pad register, two synchroniser stages and the output flop
    step(1);
    chk(b_sync[0], 1'h1);
    chk({b_oe[16], p_dn[16]}, 2'h3);
    {in_cnt, ded} = {4'h4, 20'h00020};
    step(3);
    chk({p_up[5], b_oe[5], b_oe[6]}, 3'h5);
    // keypad outputs beat pulse mapping on the extra columns
    wr(8'hA7, 8'h01);
    out_cnt = 4'hC;
    step(3);
    chk({b_oe[18:17], b_out[18:17]}, 4'h4);
    results();
  end
endmodule // tb_top
`default_nettype wire
